// ### hdl/vdsc_regs.sv
// Display status and control registers with completion flags and irq.
// Assumes timing inputs are synchronous to clock and pad_*_end pulses
// mark the last pixel leaving the output pad, one cycle each.
//
// Function
// RULE1: Frame-done status bit 30 sets on frame completion, write-1 clears.
// RULE2: Field-2-done status bit 29 sets on field 2 completion, write-1 clears.
// RULE3: Field-1-done status bit 28 sets on field 1 completion, write-1 clears.
// RULE4: Completion flags set when the final pixel reaches the pad.
// RULE5: Software must clear completion flags in time, else not-acked irq.
// RULE6: Status bits 27..16 show the live line counter.
// RULE7: Status bits 11..0 show the live pixel counter.
// RULE8: Status bit 13 shows vertical blanking.
// RULE9: Status bit 12 shows active field, updated at next vblank start.
// RULE10: Reserved status and control bits read zero, ignore writes.
// RULE11: Writing 1 to control bit 31 resets the channel, clears enable.
// RULE12: Soft-reset bit clears itself when channel reset completes.
// RULE13: Control resets with DMA block bit 30 set, others zero.
// RULE14: Control fields sit at their fixed bit positions.
// RULE15: Block stops DMA and flushes; unblock takes effect next frame.
// RULE16: Format codes 01x select narrow, 11x select wide output.
// RULE17: Display enable starts the channel.
// RULE18: Completion event beats a same-cycle write-1 clear.
`timescale 1ns/100ps
`include "vdsc_params.svh"

module vdsc_regs
    import vdsc_pkg::*;
#(
    parameter int RESET_CYC = `VDSC_RESET_CYC
) (
    input  wire logic            clock,
    input  wire logic            reset,
    input  wire vdsc_bus_type    bus,
    input  wire vdsc_timing_type timing,
    output logic [31:0]          rdata,
    output logic                 irq,
    output logic                 channel_reset,
    output logic                 display_run,
    output logic                 dma_events_en,
    output logic                 fifo_flush,
    output logic                 narrow_output,
    output logic                 wide_output,
    output logic [31:0]          control_out
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic               wr_status;
    logic               wr_control;
    logic               wr_irq_status;
    logic               wr_irq_mask;
    logic [31:0]        ctrl_r;
    logic [2:0]         done_r;
    logic               field_r;
    logic [`VDSC_IRQ_WIDTH-1:0] irq_stat_r;
    logic [`VDSC_IRQ_WIDTH-1:0] irq_mask_r;
    logic [`VDSC_IRQ_WIDTH-1:0] irq_ev;
    logic [2:0]         done_ev;
    logic [2:0]         done_clr;
    logic               soft_req;
    vdsc_rst_state_type rst_state_r;
    logic [15:0]        rst_cnt_r;
    logic               unblock_pending_r;
    logic               dma_en_r;
    logic [31:0]        status_view;

    assign wr_status     = bus.wr && (bus.addr == `VDSC_ADDR_STATUS);
    assign wr_control    = bus.wr && (bus.addr == `VDSC_ADDR_CONTROL);
    assign wr_irq_status = bus.wr && (bus.addr == `VDSC_ADDR_IRQ_STATUS);
    assign wr_irq_mask   = bus.wr && (bus.addr == `VDSC_ADDR_IRQ_MASK);
    assign soft_req      = wr_control && bus.wdata[`VDSC_CT_SOFT_RESET];

    // ------------------------------------------------------------
    // Channel reset sequencer
    // ------------------------------------------------------------
    // Held for a fixed count so downstream logic sees a clean reset
    always_ff @(posedge clock) begin
        if (reset) begin
            rst_state_r <= VDSC_IDLE;
            rst_cnt_r   <= 16'h0000;
        end else begin
            unique case (rst_state_r)
                VDSC_IDLE: begin
                    if (soft_req) begin // [RULE11]
                        rst_state_r <= VDSC_RESETTING;
                        rst_cnt_r   <= 16'(RESET_CYC);
                    end
                end
                VDSC_RESETTING: begin
                    if (rst_cnt_r <= 16'h0001) begin
                        rst_state_r <= VDSC_IDLE; // [RULE12]
                        rst_cnt_r   <= 16'h0000;
                    end else begin
                        rst_cnt_r <= rst_cnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Reset channel restores defaults, so enable drops with it
    always_ff @(posedge clock) begin
        if (reset || soft_req) begin
            ctrl_r <= `VDSC_CT_RESET_VAL; // [RULE13] [RULE11]
        end else if (wr_control && rst_state_r == VDSC_IDLE) begin
            ctrl_r <= bus.wdata & `VDSC_CT_WR_MASK; // [RULE10] [RULE14]
        end
    end

    // ------------------------------------------------------------
    // DMA event gating
    // ------------------------------------------------------------
    // Unblocking waits a frame boundary so DMA stays field-aligned
    always_ff @(posedge clock) begin
        if (reset || ctrl_r[`VDSC_CT_DMA_BLOCK]) begin
            dma_en_r          <= 1'b0; // [RULE15]
            unblock_pending_r <= 1'b1;
        end else if (unblock_pending_r && timing.frame_start) begin
            dma_en_r          <= 1'b1; // [RULE15]
            unblock_pending_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Completion flags
    // ------------------------------------------------------------
    assign done_ev  = {timing.pad_frame_end, timing.pad_field2_end,
                       timing.pad_field1_end}; // [RULE4]
    assign done_clr = wr_status ? bus.wdata[`VDSC_ST_FRAME_DONE:`VDSC_ST_FIELD1_DONE]
                                : 3'h0;

    // Set wins over clear; one flop per flag
    generate
        for (genvar i = 0; i < 3; i++) begin : g_done
            always_ff @(posedge clock) begin
                if (reset || channel_reset) begin
                    done_r[i] <= 1'b0;
                end else if (done_ev[i]) begin
                    done_r[i] <= 1'b1; // [RULE1] [RULE2] [RULE3] [RULE18]
                end else if (done_clr[i]) begin
                    done_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Active field toggles only at vblank start
    always_ff @(posedge clock) begin
        if (reset || channel_reset) begin
            field_r <= 1'b0;
        end else if (timing.vblank_start) begin
            field_r <= ~field_r; // [RULE9]
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Not-acked: a completion arrives while its flag is still set
    assign irq_ev[`VDSC_IRQ_FIELD1]     = done_ev[0];
    assign irq_ev[`VDSC_IRQ_FIELD2]     = done_ev[1];
    assign irq_ev[`VDSC_IRQ_FRAME]      = done_ev[2];
    assign irq_ev[`VDSC_IRQ_NOT_ACKED]  = |(done_ev & done_r); // [RULE5]

    generate
        for (genvar j = 0; j < `VDSC_IRQ_WIDTH; j++) begin : g_irq
            always_ff @(posedge clock) begin
                if (reset) begin
                    irq_stat_r[j] <= 1'b0;
                end else if (irq_ev[j]) begin
                    irq_stat_r[j] <= 1'b1;
                end else if (wr_irq_status && bus.wdata[j]) begin
                    irq_stat_r[j] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (reset) begin
            irq_mask_r <= '0;
        end else if (wr_irq_mask) begin
            irq_mask_r <= bus.wdata[`VDSC_IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        status_view = 32'h0000_0000; // [RULE10]
        status_view[`VDSC_ST_FRAME_DONE:`VDSC_ST_FIELD1_DONE] = done_r;
        status_view[`VDSC_ST_LINE_HI:`VDSC_ST_LINE_LO]   = timing.line_count;  // [RULE6]
        status_view[`VDSC_ST_VBLANK]                     = timing.vblank;      // [RULE8]
        status_view[`VDSC_ST_FIELD]                      = field_r;            // [RULE9]
        status_view[`VDSC_ST_PIXEL_HI:`VDSC_ST_PIXEL_LO] = timing.pixel_count; // [RULE7]
    end

    // Unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `VDSC_ADDR_STATUS:     rdata <= status_view;
                `VDSC_ADDR_CONTROL:    rdata <= ctrl_r |
                    {(rst_state_r == VDSC_RESETTING), 31'h0}; // [RULE12]
                `VDSC_ADDR_IRQ_STATUS: rdata <= {28'h0, irq_stat_r};
                `VDSC_ADDR_IRQ_MASK:   rdata <= {28'h0, irq_mask_r};
                default:               rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Channel outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            channel_reset <= 1'b0;
            display_run   <= 1'b0;
            dma_events_en <= 1'b0;
            fifo_flush    <= 1'b0;
            narrow_output <= 1'b0;
            wide_output   <= 1'b0;
            control_out   <= `VDSC_CT_RESET_VAL;
        end else begin
            channel_reset <= soft_req || (rst_state_r == VDSC_RESETTING);
            display_run   <= ctrl_r[`VDSC_CT_DISP_EN]; // [RULE17]
            dma_events_en <= dma_en_r && ctrl_r[`VDSC_CT_DISP_EN];
            fifo_flush    <= ctrl_r[`VDSC_CT_DMA_BLOCK]; // [RULE15]
            narrow_output <= (ctrl_r[`VDSC_CT_FMT_HI:`VDSC_CT_FMT_LO] == `VDSC_FMT_NARROW); // [RULE16]
            wide_output   <= (ctrl_r[`VDSC_CT_FMT_HI:`VDSC_CT_FMT_LO] == `VDSC_FMT_WIDE);   // [RULE16]
            control_out   <= ctrl_r;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_frame_done_ev;
        timing.pad_frame_end;
    endsequence

    chk_frame_flag_set: assert property (@(posedge clock) disable iff (reset) // [RULE1]
        (s_frame_done_ev and !channel_reset) |=> done_r[2])
        else $error("frame flag not set");
    chk_field2_set: assert property (@(posedge clock) disable iff (reset) // [RULE2]
        timing.pad_field2_end && !channel_reset |=> done_r[1])
        else $error("field2 flag not set");
    chk_field1_clear: assert property (@(posedge clock) disable iff (reset) // [RULE3]
        wr_status && bus.wdata[`VDSC_ST_FIELD1_DONE] && !timing.pad_field1_end |=> !done_r[0])
        else $error("field1 flag not cleared");
    chk_zero_no_clear: assert property (@(posedge clock) disable iff (reset) // [RULE1]
        wr_status && !bus.wdata[`VDSC_ST_FRAME_DONE] && done_r[2] && !channel_reset
        |=> done_r[2])
        else $error("write zero cleared flag");
    chk_field_toggle: assert property (@(posedge clock) disable iff (reset) // [RULE9]
        !timing.vblank_start && !channel_reset |=> $stable(field_r))
        else $error("field changed outside vblank start");
    chk_soft_reset_end: assert property (@(posedge clock) disable iff (reset) // [RULE12]
        soft_req && rst_state_r == VDSC_IDLE |=> rst_state_r == VDSC_RESETTING
        ##[1:8] rst_state_r == VDSC_IDLE)
        else $error("soft reset did not complete");
    chk_enable_cleared: assert property (@(posedge clock) disable iff (reset) // [RULE11]
        soft_req |=> !ctrl_r[`VDSC_CT_DISP_EN] && ctrl_r[`VDSC_CT_DMA_BLOCK])
        else $error("soft reset left enable set");
    chk_block_dma: assert property (@(posedge clock) disable iff (reset) // [RULE15]
        ctrl_r[`VDSC_CT_DMA_BLOCK] |=> !dma_en_r ##1 !dma_events_en)
        else $error("dma events while blocked");
    chk_reserved_ctrl: assert property (@(posedge clock) disable iff (reset) // [RULE10]
        (ctrl_r & ~`VDSC_CT_WR_MASK) == 32'h0)
        else $error("reserved control bit set");
    chk_set_beats_clear: assert property (@(posedge clock) disable iff (reset) // [RULE18]
        timing.pad_frame_end && done_clr[2] && !channel_reset |=> done_r[2])
        else $error("clear beat completion");

endmodule : vdsc_regs

// ### hdl/vdsc_params.svh
// Register offsets, field positions, reset values and timing counts
// for the display status/control register block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef VDSC_PARAMS_SVH
`define VDSC_PARAMS_SVH

// Register byte addresses
`define VDSC_ADDR_STATUS      8'h00
`define VDSC_ADDR_CONTROL     8'h04
`define VDSC_ADDR_IRQ_STATUS  8'h08
`define VDSC_ADDR_IRQ_MASK    8'h0c

// Status fields
`define VDSC_ST_FRAME_DONE    30
`define VDSC_ST_FIELD2_DONE   29
`define VDSC_ST_FIELD1_DONE   28
`define VDSC_ST_LINE_HI       27
`define VDSC_ST_LINE_LO       16
`define VDSC_ST_VBLANK        13
`define VDSC_ST_FIELD         12
`define VDSC_ST_PIXEL_HI      11
`define VDSC_ST_PIXEL_LO      0

// Control fields
`define VDSC_CT_SOFT_RESET    31
`define VDSC_CT_DMA_BLOCK     30
`define VDSC_CT_DISP_EN       15
// Writable control bits: everything except 31, 29, 27..24, 9, 3
`define VDSC_CT_WR_MASK       32'h50fffdf7
`define VDSC_CT_RESET_VAL     32'h40000000

// Interrupt bits
`define VDSC_IRQ_FIELD1       0
`define VDSC_IRQ_FIELD2       1
`define VDSC_IRQ_FRAME        2
`define VDSC_IRQ_NOT_ACKED    3
`define VDSC_IRQ_WIDTH        4

// Output format codes (upper two bits of the three-bit field)
`define VDSC_FMT_NARROW       2'h1
`define VDSC_FMT_WIDE         2'h3
`define VDSC_CT_FMT_HI        2
`define VDSC_CT_FMT_LO        1

// Channel reset duration
`define VDSC_RESET_NS         64
`define VDSC_CLK_NS           8
`define VDSC_RESET_CYC        ((`VDSC_RESET_NS + `VDSC_CLK_NS - 1) / `VDSC_CLK_NS)

`endif

// ### hdl/vdsc_pkg.sv
// Types shared by the display status/control register block.
// Assumes the params header is on the include path.
`include "vdsc_params.svh"

package vdsc_pkg;

    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } vdsc_bus_type;

    // Timing events from the display engine
    typedef struct packed {
        logic        pad_field1_end;
        logic        pad_field2_end;
        logic        pad_frame_end;
        logic        vblank_start;
        logic        vblank;
        logic        frame_start;
        logic [11:0] line_count;
        logic [11:0] pixel_count;
    } vdsc_timing_type;

    // Channel reset sequencer
    typedef enum logic [1:0] {
        VDSC_IDLE,
        VDSC_RESETTING
    } vdsc_rst_state_type;

endpackage : vdsc_pkg

// ### test/vdsc_regs_test.sv
// Self-checking bench for the display status/control register block.
// Assumes the hdl/ files are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`include "vdsc_params.svh"

module vdsc_regs_test
    import vdsc_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int         RST_CYC = 4;
    localparam logic [7:0] ST      = `VDSC_ADDR_STATUS;
    localparam logic [7:0] CTL     = `VDSC_ADDR_CONTROL;
    localparam logic [7:0] IST     = `VDSC_ADDR_IRQ_STATUS;
    localparam logic [7:0] MSK     = `VDSC_ADDR_IRQ_MASK;

    logic            clock = 1'b0;
    logic            reset = 1'b1;
    vdsc_bus_type    bus_q;
    vdsc_timing_type tim;
    logic [31:0]     rdata;
    logic [31:0]     control_out;
    logic            irq;
    logic            channel_reset;
    logic            display_run;
    logic            dma_events_en;
    logic            fifo_flush;
    logic            narrow_output;
    logic            wide_output;
    logic [31:0]     rd_v;
    int              fail_count = 0;
    int              num_checks = 0;

    // Short channel reset keeps the polling loop small
    vdsc_regs #(
        .RESET_CYC (RST_CYC)
    ) vdsc_regs_i (
        .clock         (clock),
        .reset         (reset),
        .bus           (bus_q),
        .timing        (tim),
        .rdata         (rdata),
        .irq           (irq),
        .channel_reset (channel_reset),
        .display_run   (display_run),
        .dma_events_en (dma_events_en),
        .fifo_flush    (fifo_flush),
        .narrow_output (narrow_output),
        .wide_output   (wide_output),
        .control_out   (control_out)
    );

    // 125 MHz clock
    always #4 clock = ~clock;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cycles

    // One-cycle write strobe, gap cycle before the next access
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_q.addr  <= a;
        bus_q.wdata <= d;
        bus_q.wr    <= 1'b1;
        @(posedge clock);
        bus_q.wr    <= 1'b0;
    endtask : bus_wr

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_q.addr <= a;
        bus_q.rd   <= 1'b1;
        @(posedge clock);
        bus_q.rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus_rd(a, v);
        check(what, exp, v);
    endtask : rd_chk

    // One-cycle timing event pulses
    task automatic pulse(input logic [2:0] ev, input logic vbs, input logic fs);
        @(posedge clock);
        tim.pad_field1_end <= ev[0];
        tim.pad_field2_end <= ev[1];
        tim.pad_frame_end  <= ev[2];
        tim.vblank_start   <= vbs;
        tim.frame_start    <= fs;
        @(posedge clock);
        tim.pad_field1_end <= 1'b0;
        tim.pad_field2_end <= 1'b0;
        tim.pad_frame_end  <= 1'b0;
        tim.vblank_start   <= 1'b0;
        tim.frame_start    <= 1'b0;
    endtask : pulse

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        bus_q = '0;
        tim   = '0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        rd_chk("control reset", CTL, 32'h40000000);
        rd_chk("status reset", ST, 32'h0);
        check("flush at reset", 32'h1, 32'(fifo_flush));
        $display("test reset values done");

        // Soft reset bit must not be hit here, so bit 31 stays clear
        bus_wr(CTL, 32'h7fffffff);
        rd_chk("control fields", CTL, 32'h50fffdf7);
        check("control out", 32'h50fffdf7, control_out);
        check("display run", 32'h1, 32'(display_run));
        for (int c = 0; c < 8; c++) begin
            bus_wr(CTL, 32'h40000000 | 32'(c));
            cycles(2);
            check("narrow", 32'(c[2:1] == 2'h1), 32'(narrow_output));
            check("wide", 32'(c[2:1] == 2'h3), 32'(wide_output));
        end
        rd_chk("unmapped read", 8'h10, 32'h0);
        bus_wr(8'h10, 32'hffffffff);
        rd_chk("unmapped write", CTL, 32'h40000007);
        $display("test control fields done");

        // Each done flag: set, survives a write of 0, cleared by a write of 1
        for (int i = 0; i < 3; i++) begin
            pulse(3'(1 << i), 1'b0, 1'b0);
            rd_chk("done set", ST, 32'h10000000 << i);
            bus_wr(ST, 32'h0);
            rd_chk("done kept", ST, 32'h10000000 << i);
            bus_wr(ST, 32'h10000000 << i);
            rd_chk("done cleared", ST, 32'h0);
            rd_chk("irq status", IST, 32'h1 << i);
            check("irq masked", 32'h0, 32'(irq));
            bus_wr(IST, 32'h1 << i);
        end
        $display("test done flags done");

        // Second frame event lands with the clear of the still-set flag
        pulse(3'h4, 1'b0, 1'b0);
        fork
            bus_wr(ST, 32'h40000000);
            pulse(3'h4, 1'b0, 1'b0);
        join
        rd_chk("set beats clear", ST, 32'h40000000);
        rd_chk("not acked", IST, 32'h0000000c);
        bus_wr(MSK, 32'h8);
        cycles(2);
        check("irq raised", 32'h1, 32'(irq));
        bus_wr(IST, 32'h4);
        cycles(2);
        check("irq kept", 32'h1, 32'(irq));
        bus_wr(IST, 32'h8);
        cycles(2);
        check("irq cleared", 32'h0, 32'(irq));
        $display("test interrupts done");

        // Unblock waits for a frame start
        bus_wr(CTL, 32'h00008000);
        cycles(2);
        check("flush off", 32'h0, 32'(fifo_flush));
        check("dma held", 32'h0, 32'(dma_events_en));
        pulse(3'h0, 1'b0, 1'b1);
        cycles(2);
        check("dma on", 32'h1, 32'(dma_events_en));
        $display("test dma block done");

        // Channel reset with the frame flag still set
        bus_wr(CTL, 32'h80000000);
        cycles(1);
        check("channel reset", 32'h1, 32'(channel_reset));
        bus_rd(CTL, rd_v);
        check("reset pending", 32'h1, 32'(rd_v[31]));
        for (int n = 0; n < 20 && rd_v[31] === 1'b1; n++) begin
            bus_rd(CTL, rd_v);
        end
        check("reset finished", 32'h40000000, rd_v);
        check("run cleared", 32'h0, 32'(display_run));
        rd_chk("flags cleared", ST, 32'h0);
        $display("test soft reset done");

        // Live counters, blanking and field bit; reserved bits written high
        @(posedge clock);
        tim.line_count  <= 12'habc;
        tim.pixel_count <= 12'h123;
        tim.vblank      <= 1'b1;
        bus_wr(ST, 32'h8000c000);
        rd_chk("live status", ST, 32'h0abc2123);
        pulse(3'h0, 1'b1, 1'b0);
        rd_chk("field two", ST, 32'h0abc3123);
        @(posedge clock);
        tim.vblank <= 1'b0;
        pulse(3'h0, 1'b1, 1'b0);
        rd_chk("field one", ST, 32'h0abc0123);
        $display("test live status done");
        stop_test();
    end

    // Whole run is under two hundred cycles; this cuts a hang short
    initial begin
        #100000;
        fail_count++;
        $display("watchdog expired");
        stop_test();
    end

endmodule : vdsc_regs_test
